// ---- rtl/pac_edge_det.sv ----
`timescale 1ns/10ps
module pac_edge_det
   import pac_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       sig,
   input  wire logic [1:0] cfg,
   output logic            hit
);
   logic prev;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         prev <= 1'b0;
      end else begin
         prev <= sig;
      end
   end
   always_comb begin
      // [R5] Rising, falling or both-edge detect on the gated input
      unique case (pac_edge_e'(cfg))
         PAC_EDGE_RISING:  hit = sig & ~prev;
         PAC_EDGE_FALLING: hit = ~sig & prev;
         PAC_EDGE_BOTH:    hit = sig ^ prev;
         default:          hit = 1'b0;
      endcase
   end
endmodule : pac_edge_det

// ---- rtl/pac_pin_cell.sv ----
`timescale 1ns/10ps
module pac_pin_cell
   import pac_pkg::*;
(
   input  wire logic alt_sel,
   input  wire logic dir_in,
   input  wire logic od_sel,
   input  wire logic latch,
   input  wire logic alt_out,
   input  wire logic alt_out_en,
   input  wire logic pin_in,
   output logic      drive_val,
   output logic      drive_en,
   output logic      periph_in,
   output logic      read_val
);
   logic val;
   always_comb begin
      // [R1] Gated peripheral input
      periph_in = alt_sel & pin_in;
      val       = alt_sel ? alt_out : latch;
      // [R8] Open drain in output
      if (alt_sel) begin
         drive_en = alt_out_en & (~od_sel | ~alt_out);
      end else if (!dir_in) begin
         drive_en = ~od_sel | ~latch;
      end else begin
         drive_en = 1'b0;
      end
      drive_val = val;
      // [R9] Input reads pin
      read_val  = dir_in ? pin_in : latch;
   end
endmodule : pac_pin_cell

// ---- rtl/pac_pkg.sv ----
package pac_pkg;
   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_PORT_DATA   = 8'h00;
   localparam logic [7:0] OFS_DIRECTION   = 8'h04;
   localparam logic [7:0] OFS_ALT_SELECT  = 8'h08;
   localparam logic [7:0] OFS_OPEN_DRAIN  = 8'h0c;
   localparam logic [7:0] OFS_BIT_MANIP   = 8'h10;
   localparam logic [7:0] OFS_EDGE_CFG    = 8'h14;
   localparam logic [7:0] OFS_DEBUG_MODE  = 8'h18;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h1c;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h20;
   localparam logic [7:0] OFS_RESET_CAUSE = 8'h24;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int IRQ_PIN_POS    = 2;
   localparam int DEBUG_PIN_POS  = 5;
   localparam int MANIP_BIT_LSB  = 0;
   localparam int MANIP_VAL_POS  = 3;
   localparam int ST_NMI_POS     = 0;
   localparam int ST_DBG_POS     = 1;
   localparam int RC_EXT_POS     = 0;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_DIRECTION  = 8'hff;
   localparam logic [7:0] RST_ALT_SELECT = 8'h00;
   localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
   localparam logic [7:0] RST_PORT_DATA  = 8'h00;
   localparam logic [1:0] RST_EDGE_CFG   = 2'h0;
   localparam logic       RST_DEBUG_EN   = 1'b1;
   // ------------------------------------------------------------
   // Edge detection settings
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      PAC_EDGE_NONE    = 2'h0,
      PAC_EDGE_RISING  = 2'h1,
      PAC_EDGE_FALLING = 2'h2,
      PAC_EDGE_BOTH    = 2'h3
   } pac_edge_e;
endpackage : pac_pkg

// ---- rtl/pac_port.sv ----
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
// Functional notes
// [R1] A peripheral input sees the AND of its select bit and the pin level.
// [R2] Software sets the select bit before enabling the peripheral.
// [R3] Software stops the peripheral before clearing the select bit.
// [R4] Selecting the irq pin with a high level and rising edge fires nmi.
// [R5] Deselecting it with a high level and falling edge fires nmi.
// [R6] Software programs the valid edge after selecting the irq function.
// [R7] Software sets no-edge before returning the irq pin to port use.
// [R8] Open-drain acts in port mode only when the direction is output.
// [R9] Data writes go to the latch; input pins read the pin level.
// [R10] A bit operation reads 8 bits, changes one, writes all 8 back.
// [R11] Software rewrites the latch when turning an input into output.
// [R12] External reset gives the debug pin its debug role; high enters debug.
// [R13] Software clears debug enable; the pin is held low until then.
// [R14] Other resets keep the debug pin role and debug mode register.
// [R15] The debug pull-down is on after external reset, off once cleared.
// [R16] Software orders open-drain, function, select, then interrupt setup.
// [R17] Select, open-drain and direction reset to port, push-pull, input.
module pac_port
   import pac_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        ext_reset_cause,
   input  wire logic [31:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  pin_in,
   output logic      [7:0]  pin_out,
   output logic      [7:0]  pin_oe,
   input  wire logic [7:0]  alt_out,
   input  wire logic [7:0]  alt_out_en,
   output logic      [7:0]  periph_in,
   output logic             nmi,
   output logic             debug_active,
   output logic             debug_pulldown,
   output logic             irq
);
   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [7:0] port_data_reg;
   logic [7:0] port_direction_reg;
   logic [7:0] alt_function_select_reg;
   logic [7:0] open_drain_select_reg;
   logic [1:0] edge_cfg;
   logic       debug_enable_bit;
   logic       pulldown_on;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic       last_ext;
   logic [7:0] drv_val;
   logic [7:0] drv_en;
   logic [7:0] per_in;
   logic [7:0] rd_val;
   logic       edge_hit;
   logic       wr;
   logic       rd;
   logic       mapped;
   logic [7:0] next_manip;
   logic [31:0] next_rdata;
   // ------------------------------------------------------------
   // Pin cells
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         pac_pin_cell u_cell (
            .alt_sel    (alt_function_select_reg[g]),
            .dir_in     (port_direction_reg[g]),
            .od_sel     (open_drain_select_reg[g]),
            .latch      (port_data_reg[g]),
            .alt_out    (alt_out[g]),
            .alt_out_en (alt_out_en[g]),
            .pin_in     (pin_in[g]),
            .drive_val  (drv_val[g]),
            .drive_en   (drv_en[g]),
            .periph_in  (per_in[g]),
            .read_val   (rd_val[g])
         );
      end
   endgenerate
   // ------------------------------------------------------------
   // Nmi edge detector on gated input
   // ------------------------------------------------------------
   // [R4] Gated edge source
   pac_edge_det u_edge (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .sig     (per_in[IRQ_PIN_POS]),
      .cfg     (edge_cfg),
      .hit     (edge_hit)
   );
   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   assign wr = psel & penable & pwrite & pready;
   assign rd = psel & penable & ~pwrite & pready;
   always_comb begin
      mapped     = 1'b1;
      next_rdata = 32'h0000_0000;
      // [R10] Read 8, modify one bit
      next_manip = rd_val;
      next_manip[pwdata[MANIP_BIT_LSB +: 3]] = pwdata[MANIP_VAL_POS];
      unique case (paddr[7:0])
         OFS_PORT_DATA:   next_rdata[7:0] = rd_val;
         OFS_DIRECTION:   next_rdata[7:0] = port_direction_reg;
         OFS_ALT_SELECT:  next_rdata[7:0] = alt_function_select_reg;
         OFS_OPEN_DRAIN:  next_rdata[7:0] = open_drain_select_reg;
         OFS_BIT_MANIP:   next_rdata[7:0] = rd_val;
         OFS_EDGE_CFG:    next_rdata[1:0] = edge_cfg;
         OFS_DEBUG_MODE:  next_rdata[0]   = debug_enable_bit;
         OFS_IRQ_STATUS:  next_rdata[1:0] = irq_status;
         OFS_IRQ_MASK:    next_rdata[1:0] = irq_mask;
         OFS_RESET_CAUSE: next_rdata[RC_EXT_POS] = last_ext;
         default:         mapped = 1'b0;
      endcase
   end
   // Two-cycle access: one wait state then ready
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         if (psel & penable & ~pready & ~pwrite) begin
            prdata <= next_rdata;
         end
      end
   end
   // ------------------------------------------------------------
   // Port configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         // [R17] Port mode input push-pull
         port_direction_reg      <= RST_DIRECTION;
         alt_function_select_reg <= RST_ALT_SELECT;
         open_drain_select_reg   <= RST_OPEN_DRAIN;
         edge_cfg                <= RST_EDGE_CFG;
         irq_mask                <= 2'h0;
      end else if (wr) begin
         unique case (paddr[7:0])
            OFS_DIRECTION:  port_direction_reg      <= pwdata[7:0];
            OFS_ALT_SELECT: alt_function_select_reg <= pwdata[7:0];
            OFS_OPEN_DRAIN: open_drain_select_reg   <= pwdata[7:0];
            OFS_EDGE_CFG:   edge_cfg                <= pwdata[1:0];
            OFS_IRQ_MASK:   irq_mask                <= pwdata[1:0];
            default:        ;
         endcase
      end
   end
   // ------------------------------------------------------------
   // Output latch
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         port_data_reg <= RST_PORT_DATA;
      end else if (wr && paddr[7:0] == OFS_PORT_DATA) begin
         // [R9] Write always to latch
         port_data_reg <= pwdata[7:0];
      end else if (wr && paddr[7:0] == OFS_BIT_MANIP) begin
         // [R10] Write all 8 back
         port_data_reg <= next_manip;
      end
   end
   // ------------------------------------------------------------
   // Debug pin control
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         last_ext <= ext_reset_cause;
      end else begin
         last_ext <= last_ext;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst && ext_reset_cause) begin
         // [R12] External reset gives debug role
         debug_enable_bit <= RST_DEBUG_EN;
         // [R15] Pull-down connected
         pulldown_on      <= 1'b1;
      end else if (sys_rst) begin
         // [R14] Other resets keep debug state
         debug_enable_bit <= debug_enable_bit;
         pulldown_on      <= pulldown_on;
      end else if (wr && paddr[7:0] == OFS_DEBUG_MODE) begin
         // [R13] Software clears debug enable
         debug_enable_bit <= pwdata[0];
         // [R15] Pull-down off once cleared
         if (!pwdata[0]) begin
            pulldown_on <= 1'b0;
         end
      end
   end
   // ------------------------------------------------------------
   // Interrupt status
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         irq_status <= 2'h0;
      end else begin
         if (wr && paddr[7:0] == OFS_IRQ_STATUS) begin
            irq_status <= irq_status & ~pwdata[1:0];
         end
         // [R5] Edge sets status, wins over clear
         if (edge_hit) begin
            irq_status[ST_NMI_POS] <= 1'b1;
         end
         if (debug_enable_bit && pin_in[DEBUG_PIN_POS] && !debug_active) begin
            irq_status[ST_DBG_POS] <= 1'b1;
         end
      end
   end
   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pin_out        <= 8'h00;
         pin_oe         <= 8'h00;
         periph_in      <= 8'h00;
         nmi            <= 1'b0;
         debug_active   <= 1'b0;
         debug_pulldown <= 1'b0;
         irq            <= 1'b0;
      end else begin
         pin_out        <= drv_val;
         pin_oe         <= drv_en;
         periph_in      <= per_in;
         // [R4] Nmi on detected edge
         nmi            <= edge_hit;
         // [R12] High level enters debug
         debug_active   <= debug_enable_bit & pin_in[DEBUG_PIN_POS];
         debug_pulldown <= pulldown_on;
         irq            <= |(irq_status & irq_mask);
      end
   end
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence sel_rise_s;
      $rose(alt_function_select_reg[IRQ_PIN_POS]);
   endsequence
   gate_low_a: assert property ( // [R1]
      !alt_function_select_reg[0] |=> !periph_in[0])
      else $error("peripheral input not gated");
   rise_nmi_a: assert property ( // [R4]
      (sel_rise_s and pin_in[IRQ_PIN_POS] and
       $past(pin_in[IRQ_PIN_POS]) and edge_cfg == PAC_EDGE_RISING
       and $stable(edge_cfg)) |=> nmi)
      else $error("rising select edge missed");
   fall_nmi_a: assert property ( // [R5]
      ($fell(alt_function_select_reg[IRQ_PIN_POS]) and
       $past(pin_in[IRQ_PIN_POS]) and edge_cfg == PAC_EDGE_FALLING
       and $stable(edge_cfg)) |=> nmi)
      else $error("falling select edge missed");
   od_input_a: assert property ( // [R8]
      (!alt_function_select_reg[0] && port_direction_reg[0])
      |=> !pin_oe[0])
      else $error("input pin driven");
   rd_pin_a: assert property ( // [R9]
      (psel && penable && !pready && !pwrite &&
       paddr[7:0] == OFS_PORT_DATA && port_direction_reg[1])
      |=> prdata[1] == $past(pin_in[1]))
      else $error("pin read wrong");
   rd_latch_a: assert property ( // [R9]
      (psel && penable && !pready && !pwrite &&
       paddr[7:0] == OFS_PORT_DATA && !port_direction_reg[0])
      |=> prdata[0] == $past(port_data_reg[0]))
      else $error("latch read wrong");
   manip_wr_a: assert property ( // [R10]
      (wr && paddr[7:0] == OFS_BIT_MANIP)
      |=> (((port_data_reg ^ $past(pin_in)) & $past(port_direction_reg)
            & ~(8'h01 << $past(pwdata[MANIP_BIT_LSB +: 3]))) == 8'h00)
          && port_data_reg[$past(pwdata[MANIP_BIT_LSB +: 3])]
             == $past(pwdata[MANIP_VAL_POS]))
      else $error("bit operation lost pin levels");
   dbg_clr_a: assert property ( // [R15]
      (wr && paddr[7:0] == OFS_DEBUG_MODE && !pwdata[0])
      |=> ##1 !debug_pulldown)
      else $error("pull-down not released");
   keep_dbg_a: assert property ( // [R14]
      disable iff (1'b0)
      (sys_rst && !ext_reset_cause)
      |=> $stable(debug_enable_bit) && $stable(pulldown_on))
      else $error("debug mode changed by reset");
   dbg_off_a: assert property ( // [R13]
      (wr && paddr[7:0] == OFS_DEBUG_MODE && !pwdata[0])
      |=> ##1 !debug_active)
      else $error("debug mode not left");
   irq_lvl_a: assert property (
      1'b1 |=> irq == $past((irq_status & irq_mask) != 2'h0))
      else $error("interrupt level wrong");
endmodule : pac_port

// ---- verif/pac_pin_model.sv ----
`timescale 1ns/10ps
module pac_pin_model (
   input  wire logic [7:0] ext_level,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   output logic      [7:0] pin_in,
   output logic      [7:0] alt_out,
   output logic      [7:0] alt_out_en
);
   // ------------------------------------------------------------
   // Pin wires and peripherals
   // ------------------------------------------------------------
   // Port drive wins, else outside level
   assign pin_in     = (pin_oe & pin_out) | (~pin_oe & ext_level);
   assign alt_out    = 8'h00;
   assign alt_out_en = 8'h00;
endmodule : pac_pin_model

// ---- verif/pac_port_tb.sv ----
`timescale 1ns/10ps
module pac_port_tb;
   import pac_pkg::*;
   logic        sys_clk;
   logic        sys_rst;
   logic        ext_reset_cause;
   logic [31:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  pin_in;
   logic [7:0]  pin_out;
   logic [7:0]  pin_oe;
   logic [7:0]  alt_out;
   logic [7:0]  alt_out_en;
   logic [7:0]  periph_in;
   logic        nmi;
   logic        debug_active;
   logic        debug_pulldown;
   logic        irq;
   logic [7:0]  ext_level;
   int          bad_count;
   int          check_count;
   int          nmi_cnt;
   pac_port pac_port_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .ext_reset_cause(ext_reset_cause), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .alt_out(alt_out), .alt_out_en(alt_out_en), .periph_in(periph_in),
      .nmi(nmi), .debug_active(debug_active),
      .debug_pulldown(debug_pulldown), .irq(irq));
   pac_pin_model pac_pin_model_inst (.ext_level(ext_level),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
      .alt_out(alt_out), .alt_out_en(alt_out_en));
   // ------------------------------------------------------------
   // Clock, monitor and helpers
   // ------------------------------------------------------------
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (nmi === 1'b1) nmi_cnt++;
   end
   task automatic print_verdict;
      if (bad_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {24'h0, a};
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      q   = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
      logic [31:0] q;
      logic        er;
      apb(1'b0, a, 32'h0, q, er);
      chk(nm, e, q);
   endtask : rdc
   task automatic settle;
      repeat (4) @(posedge sys_clk);
   endtask : settle
   task automatic do_reset(input logic cause);
      @(posedge sys_clk);
      sys_rst         <= 1'b1;
      ext_reset_cause <= cause;
      repeat (20) @(posedge sys_clk);
      sys_rst         <= 1'b0;
      ext_reset_cause <= 1'b0;
      @(posedge sys_clk);
   endtask : do_reset
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset_debug;
      chk("oe", 0, pin_oe);
      rdc("dir", OFS_DIRECTION, 32'hff);
      rdc("alt", OFS_ALT_SELECT, 32'h0);
      rdc("od", OFS_OPEN_DRAIN, 32'h0);
      chk("pulldown", 1, debug_pulldown);
      rdc("dbgen", OFS_DEBUG_MODE, 32'h1);
      rdc("cause", OFS_RESET_CAUSE, 32'h1);
      ext_level <= 8'h20;
      settle();
      chk("dbgact", 1, debug_active);
      rdc("dbgseen", OFS_IRQ_STATUS, 32'h2);
      ext_level <= 8'h00;
      wr(OFS_DEBUG_MODE, 32'h0);
      settle();
      chk("pulldown", 0, debug_pulldown);
      chk("dbgact", 0, debug_active);
      do_reset(1'b0);
      rdc("dbgkeep", OFS_DEBUG_MODE, 32'h0);
      chk("pdkeep", 0, debug_pulldown);
      rdc("cause", OFS_RESET_CAUSE, 32'h0);
      do_reset(1'b1);
      settle();
      chk("pdext", 1, debug_pulldown);
      rdc("dbgext", OFS_DEBUG_MODE, 32'h1);
      wr(OFS_DEBUG_MODE, 32'h0);
   endtask : t_reset_debug
   task automatic t_edges;
      int c;
      ext_level <= 8'hdf;
      wr(OFS_IRQ_STATUS, 32'h3);
      wr(OFS_EDGE_CFG, PAC_EDGE_RISING);
      c = nmi_cnt;
      wr(OFS_ALT_SELECT, 32'h04);
      settle();
      chk("nmi_rise", c + 1, nmi_cnt);
      rdc("status", OFS_IRQ_STATUS, 32'h1);
      chk("irq_masked", 0, irq);
      wr(OFS_IRQ_MASK, 32'h1);
      settle();
      chk("irq_on", 1, irq);
      wr(OFS_IRQ_STATUS, 32'h1);
      settle();
      chk("irq_off", 0, irq);
      wr(OFS_EDGE_CFG, PAC_EDGE_FALLING);
      c = nmi_cnt;
      wr(OFS_ALT_SELECT, 32'h00);
      settle();
      chk("nmi_fall", c + 1, nmi_cnt);
      wr(OFS_ALT_SELECT, 32'h04);
      wr(OFS_EDGE_CFG, PAC_EDGE_NONE);
      wr(OFS_ALT_SELECT, 32'h00);
      wr(OFS_ALT_SELECT, 32'h04);
      wr(OFS_EDGE_CFG, PAC_EDGE_BOTH);
      settle();
      chk("nmi_quiet", c + 1, nmi_cnt);
      wr(OFS_ALT_SELECT, 32'h00);
      settle();
      chk("nmi_both", c + 2, nmi_cnt);
      wr(OFS_EDGE_CFG, PAC_EDGE_NONE);
   endtask : t_edges
   task automatic t_gate;
      ext_level <= 8'ha5;
      wr(OFS_ALT_SELECT, 32'h00);
      settle();
      chk("periph_off", 0, periph_in);
      wr(OFS_ALT_SELECT, 32'h0f);
      settle();
      chk("periph_on", 32'h05, periph_in);
      wr(OFS_ALT_SELECT, 32'h00);
   endtask : t_gate
   task automatic t_port;
      logic [31:0] q;
      logic        e;
      ext_level <= 8'hff;
      wr(OFS_DIRECTION, 32'hfe);
      wr(OFS_PORT_DATA, 32'h00);
      settle();
      chk("oe_pp", 32'h01, pin_oe);
      rdc("readback", OFS_PORT_DATA, 32'hfe);
      wr(OFS_OPEN_DRAIN, 32'h01);
      wr(OFS_PORT_DATA, 32'h01);
      settle();
      chk("oe_od_hi", 32'h00, pin_oe);
      wr(OFS_DIRECTION, 32'hff);
      wr(OFS_PORT_DATA, 32'h00);
      settle();
      chk("oe_in", 32'h00, pin_oe);
      wr(OFS_OPEN_DRAIN, 32'h00);
      wr(OFS_DIRECTION, 32'hfe);
      wr(OFS_PORT_DATA, 32'h00);
      wr(OFS_BIT_MANIP, 32'h08);
      wr(OFS_DIRECTION, 32'h00);
      settle();
      chk("bitop", 32'hff, pin_out);
      wr(OFS_PORT_DATA, 32'h00);
      settle();
      chk("rewrite", 32'h00, pin_out);
      apb(1'b0, 8'h30, 32'h0, q, e);
      chk("slverr", 1, e);
   endtask : t_port
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      sys_clk = 0;
      sys_rst = 1;
      ext_reset_cause = 1;
      paddr = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      pwdata = 0;
      ext_level = 8'h00;
      bad_count = 0;
      check_count = 0;
      nmi_cnt = 0;
      do_reset(1'b1);
      t_reset_debug();
      t_edges();
      t_gate();
      t_port();
      print_verdict();
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      bad_count++;
      print_verdict();
   end
endmodule : pac_port_tb
